// ### verilog/ipt_regs.svh
// Purpose: Register map, field positions and constants of the pending/threshold block
// Assumes: Included by bare name
// Notes:   Byte addresses on the AXI4-Lite slave
`ifndef IPT_REGS_SVH
`define IPT_REGS_SVH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define IPT_OFF_PEND3      8'h28
`define IPT_OFF_PEND4      8'h2c
`define IPT_OFF_THRESH     8'h40
`define IPT_OFF_CFG        8'h48
`define IPT_OFF_IRQ_STAT   8'h80
`define IPT_OFF_IRQ_MASK   8'h84

// ----------------------------------------------------------------
// Fields and values
// ----------------------------------------------------------------
`define IPT_PEND4_W        8
`define IPT_THR_HI         7
`define IPT_THR_LO         5
`define IPT_KEY_HI         31
`define IPT_KEY_LO         16
`define IPT_SYSTEM_RESET_REQUEST_BIT     7
`define IPT_KEY_FIRST      16'hfa05
`define IPT_KEY_SECOND     16'hbcaf
`define IPT_KEY_THIRD      16'hbeef
`define IPT_ZERO32         32'h0000_0000
`define IPT_ZERO8          8'h00
`define IPT_ZERO3          3'h0
`define IPT_RESP_OKAY      2'h0
`define IPT_RESP_SLVERR    2'h2
`define IPT_ST_RESET       4'h0
`define IPT_ST_THRESH      4'h1
`define IPT_ST_NEWPEND     4'h2
`define IPT_RST_PULSE_NS   20
`define IPT_CLK_NS         5

`endif

// ### verilog/ipt_pkg.sv
// Purpose: Types of the pending/threshold block
// Assumes: Nothing
// Notes:   Constants live in ipt_regs.svh
package ipt_pkg;
    typedef enum logic [2:0] {
        IPT_RST_IDLE  = 3'b001,
        IPT_RST_PULSE = 3'b010,
        IPT_RST_HOLD  = 3'b100
    } ipt_rst_state_type;
endpackage : ipt_pkg

// ### verilog/ipt_thresh_filter.sv
// Purpose: Priority threshold gate for each pending source
// Assumes: Priority in consecutive PW-bit fields, one per source, larger value is higher priority
// Notes:   Purely combinational
module ipt_thresh_filter #(
    parameter int NSRC = 40,
    parameter int PW   = 3
) (
    input  wire logic [NSRC-1:0]    pending,
    input  wire logic [NSRC*PW-1:0] prio,
    input  wire logic [PW-1:0]      thresh,
    output logic      [NSRC-1:0]    serviceable
);
    // Elaboration check on the gate shape
    if (NSRC < 1 || PW < 1) begin : g_bad_param
        $error("ipt_thresh_filter bad parameters");
    end

    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : g_src
            assign serviceable[g] = pending[g] &&
                ((thresh == '0) || (prio[g*PW +: PW] >= thresh));
        end
    endgenerate
endmodule : ipt_thresh_filter

// ### verilog/ipt_core.sv
// Contract
// - Word three holds pending bits of sources 64..95, read-only, resets zero.
// - A pending bit reads 1 while pending, 0 otherwise.
// - Word four holds sources 96..103 in bits 7:0; upper bits read zero.
// - Nonzero threshold blocks servicing of pending sources with lower priority.
// - Threshold zero disables filtering; register resets to zero.
// - Only threshold bits 7:5 are stored; bits 4:0 read zero.
// - Key field of the configuration register is write-only, reads zero.
// - Protected bit changes only with matching key in the same write.
// - Reset request bit plus third key in one write resets the system.
// - Writing 1 requests reset, writing 0 does nothing; bit self-clears.
// - Request acts exactly like the system control register reset bit.
//
// Purpose: Pending status 64..103, priority threshold and keyed reset request
// Assumes: AXI4-Lite slave, one clock ref_clk, async active-low rstn
// Notes:   Reset request is a pulse merged with the system control path
module ipt_core #(
    parameter int NSRC     = 40,
    parameter int PW       = 3,
    parameter int ADDR_W   = 8
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    output logic      [1:0]           s_axi_bresp,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    input  wire logic [ADDR_W-1:0]    s_axi_araddr,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic      [31:0]          s_axi_rdata,
    output logic      [1:0]           s_axi_rresp,
    input  wire logic [NSRC-1:0]      src_pending,
    input  wire logic [NSRC*PW-1:0]   src_prio,
    input  wire logic                 sctl_system_reset_request_req,
    output logic      [NSRC-1:0]      serviceable,
    output logic                      sys_reset_req,
    output logic                      irq
);
`include "ipt_regs.svh"

    // Elaboration check: the read mux is sized for exactly 40 sources
    if (NSRC != 40 || PW < 1 || PW > 8 || ADDR_W < 8) begin : g_bad_param
        $error("ipt_core bad parameters");
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [NSRC-1:0]  pend_ff;
    logic [2:0]       thr_ff;
    logic [3:0]       istat_ff;
    logic [3:0]       imask_ff;
    logic             system_reset_request_ff;
    logic [NSRC-1:0]  pend_prev_ff;
    logic             aw_ff;
    logic             w_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [31:0]      wdata_ff;
    logic [3:0]       wstrb_ff;
    logic             bvalid_ff;
    logic [1:0]       bresp_ff;
    logic             rvalid_ff;
    logic [31:0]      rdata_ff;
    logic [1:0]       rresp_ff;
    ipt_pkg::ipt_rst_state_type rst_st_ff;

    logic             wr_go;
    logic             rd_go;
    logic             key_ok;
    logic             rst_fire;
    logic [31:0]      nxt_rdata;
    logic [1:0]       nxt_rresp;
    logic [3:0]       ev_set;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == `IPT_OFF_PEND3) || (a == `IPT_OFF_PEND4) ||
                    (a == `IPT_OFF_THRESH) || (a == `IPT_OFF_CFG) ||
                    (a == `IPT_OFF_IRQ_STAT) || (a == `IPT_OFF_IRQ_MASK);
    endfunction : is_mapped

    // ----------------------------------------------------------------
    // Write channel
    // ----------------------------------------------------------------
    assign s_axi_awready = !aw_ff && !bvalid_ff;
    assign s_axi_wready  = !w_ff && !bvalid_ff;
    assign wr_go         = aw_ff && w_ff && !bvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            aw_ff     <= 1'b0;
            w_ff      <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff  <= `IPT_ZERO32;
            wstrb_ff  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff     <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_ff <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff     <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end else if (wr_go) begin
                w_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= `IPT_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= is_mapped(awaddr_ff) ? `IPT_RESP_OKAY : `IPT_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Threshold and mask
    // ----------------------------------------------------------------
    // Keep bits 7:5 only
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            thr_ff <= `IPT_ZERO3;
        end else if (wr_go && awaddr_ff == `IPT_OFF_THRESH && wstrb_ff[0]) begin
            thr_ff <= wdata_ff[`IPT_THR_HI:`IPT_THR_LO];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            imask_ff <= 4'h0;
        end else if (wr_go && awaddr_ff == `IPT_OFF_IRQ_MASK && wstrb_ff[0]) begin
            imask_ff <= wdata_ff[3:0];
        end
    end

    // ----------------------------------------------------------------
    // Keyed reset request
    // ----------------------------------------------------------------
    // Key in same write
    assign key_ok = wr_go && awaddr_ff == `IPT_OFF_CFG && (&wstrb_ff[3:2]) &&
                    wdata_ff[`IPT_KEY_HI:`IPT_KEY_LO] == `IPT_KEY_THIRD;
    assign rst_fire = (key_ok && wstrb_ff[0] && wdata_ff[`IPT_SYSTEM_RESET_REQUEST_BIT]) ||
                      sctl_system_reset_request_req;

    // One-cycle pulse, then held off until the request source drops
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_st_ff <= ipt_pkg::IPT_RST_IDLE;
            system_reset_request_ff <= 1'b0;
        end else begin
            unique case (rst_st_ff)
                ipt_pkg::IPT_RST_IDLE: begin
                    system_reset_request_ff <= rst_fire;
                    if (rst_fire) begin
                        rst_st_ff <= ipt_pkg::IPT_RST_PULSE;
                    end
                end
                ipt_pkg::IPT_RST_PULSE: begin
                    system_reset_request_ff <= 1'b0;
                    rst_st_ff <= ipt_pkg::IPT_RST_HOLD;
                end
                ipt_pkg::IPT_RST_HOLD: begin
                    system_reset_request_ff <= 1'b0;
                    if (!sctl_system_reset_request_req) begin
                        rst_st_ff <= ipt_pkg::IPT_RST_IDLE;
                    end
                end
                default: begin
                    system_reset_request_ff <= 1'b0;
                    rst_st_ff <= ipt_pkg::IPT_RST_IDLE;
                end
            endcase
        end
    end
    assign sys_reset_req = system_reset_request_ff;

    // ----------------------------------------------------------------
    // Pending capture and filter
    // ----------------------------------------------------------------
    // Pending reflects sources
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pend_ff      <= '0;
            pend_prev_ff <= '0;
        end else begin
            pend_ff      <= src_pending;
            pend_prev_ff <= pend_ff;
        end
    end

    ipt_thresh_filter #(
        .NSRC (NSRC),
        .PW   (PW)
    ) u_filter (
        .pending     (pend_ff),
        .prio        (src_prio),
        .thresh      (thr_ff),
        .serviceable (serviceable)
    );

    // ----------------------------------------------------------------
    // Interrupt status
    // ----------------------------------------------------------------
    assign ev_set = {1'b0,
                     |(pend_ff & ~pend_prev_ff),
                     (wr_go && awaddr_ff == `IPT_OFF_THRESH),
                     rst_fire};

    // Set wins over the read clear
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            istat_ff <= 4'h0;
        end else if (rd_go && s_axi_araddr == `IPT_OFF_IRQ_STAT) begin
            istat_ff <= ev_set;
        end else begin
            istat_ff <= istat_ff | ev_set;
        end
    end
    assign irq = |(istat_ff & imask_ff);

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    assign s_axi_arready = !rvalid_ff;
    assign rd_go         = s_axi_arvalid && s_axi_arready;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    always_comb begin
        nxt_rdata = `IPT_ZERO32;
        nxt_rresp = `IPT_RESP_OKAY;
        unique case (s_axi_araddr)
            `IPT_OFF_PEND3:    nxt_rdata = pend_ff[31:0];
            `IPT_OFF_PEND4:    nxt_rdata = {24'h00_0000, pend_ff[NSRC-1:32]};
            `IPT_OFF_THRESH:   nxt_rdata = {24'h00_0000, thr_ff, 5'h00};
            `IPT_OFF_CFG:      nxt_rdata = `IPT_ZERO32;
            `IPT_OFF_IRQ_STAT: nxt_rdata = {28'h000_0000, istat_ff};
            `IPT_OFF_IRQ_MASK: nxt_rdata = {28'h000_0000, imask_ff};
            default:           nxt_rresp = `IPT_RESP_SLVERR;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= `IPT_ZERO32;
            rresp_ff  <= `IPT_RESP_OKAY;
        end else if (rd_go) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= nxt_rresp;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_key_write;
        key_ok && wstrb_ff[0] && wdata_ff[`IPT_SYSTEM_RESET_REQUEST_BIT] && rst_st_ff == ipt_pkg::IPT_RST_IDLE;
    endsequence

    property p_system_reset_request_key;
        @(posedge ref_clk) disable iff (!rstn)
        s_key_write |=> sys_reset_req ##1 !sys_reset_req;
    endproperty
    a_system_reset_request_key: assert property (p_system_reset_request_key) else $error("reset request missing");

    property p_system_reset_request_cause;
        @(posedge ref_clk) disable iff (!rstn)
        $rose(sys_reset_req) |-> $past(rst_fire);
    endproperty
    a_system_reset_request_cause: assert property (p_system_reset_request_cause) else $error("reset without key");

    property p_system_reset_request_short;
        @(posedge ref_clk) disable iff (!rstn)
        sys_reset_req |=> !sys_reset_req;
    endproperty
    a_system_reset_request_short: assert property (p_system_reset_request_short) else $error("reset not self-clearing");

    property p_sctl_same;
        @(posedge ref_clk) disable iff (!rstn)
        (sctl_system_reset_request_req && rst_st_ff == ipt_pkg::IPT_RST_IDLE) |=> sys_reset_req;
    endproperty
    a_sctl_same: assert property (p_sctl_same) else $error("control reset differs");

    property p_pend_follow;
        @(posedge ref_clk) disable iff (!rstn)
        ##1 pend_ff == $past(src_pending);
    endproperty
    a_pend_follow: assert property (p_pend_follow) else $error("pending not tracking");

    property p_thr_zero_pass;
        @(posedge ref_clk) disable iff (!rstn)
        thr_ff == `IPT_ZERO3 |-> serviceable == pend_ff;
    endproperty
    a_thr_zero_pass: assert property (p_thr_zero_pass) else $error("zero threshold filters");

    property p_thr_block;
        @(posedge ref_clk) disable iff (!rstn)
        (thr_ff != `IPT_ZERO3 && src_prio[PW-1:0] < thr_ff) |-> !serviceable[0];
    endproperty
    a_thr_block: assert property (p_thr_block) else $error("low priority serviced");

    property p_rd_pend4;
        @(posedge ref_clk) disable iff (!rstn)
        (rd_go && s_axi_araddr == `IPT_OFF_PEND4) |=> s_axi_rdata[31:8] == 24'h00_0000;
    endproperty
    a_rd_pend4: assert property (p_rd_pend4) else $error("word four upper bits set");

    property p_rd_thr;
        @(posedge ref_clk) disable iff (!rstn)
        (rd_go && s_axi_araddr == `IPT_OFF_THRESH) |=> s_axi_rdata[4:0] == 5'h00;
    endproperty
    a_rd_thr: assert property (p_rd_thr) else $error("threshold low bits set");

    property p_rd_cfg;
        @(posedge ref_clk) disable iff (!rstn)
        (rd_go && s_axi_araddr == `IPT_OFF_CFG) |=> s_axi_rdata == `IPT_ZERO32;
    endproperty
    a_rd_cfg: assert property (p_rd_cfg) else $error("key field readable");

    property p_ro_write;
        @(posedge ref_clk) disable iff (!rstn)
        (wr_go && awaddr_ff == `IPT_OFF_PEND3) |=> pend_ff == $past(src_pending);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only word written");
endmodule : ipt_core

// ### testbench/ipt_src_model.sv
// Purpose: Source side of the block, pending levels and priorities
// Assumes: Levels change only just after a rising edge
// Notes:   Core view reduced to one serviced flag
module ipt_src_model (
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    input  wire logic [39:0]  pend_cmd,
    input  wire logic [119:0] prio_cmd,
    input  wire logic [39:0]  serviceable,
    output logic      [39:0]  src_pending,
    output logic      [119:0] src_prio,
    output logic              serviced
);
    // Launched on the edge so the block never samples a moving level
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            src_pending <= 40'h00_0000_0000;
            src_prio    <= 120'h0;
        end else begin
            src_pending <= pend_cmd;
            src_prio    <= prio_cmd;
        end
    end
    // Core takes whatever the filter lets through
    assign serviced = |serviceable;
endmodule : ipt_src_model

// ### testbench/tb_irq_pending_threshold_cfg.sv
// Purpose: Self-checking bench of the pending/threshold/keyed reset block
// Assumes: AXI4-Lite master here, source model on the far side
// Notes:   Fixed waits cover the one-cycle reset pulse latency
`include "ipt_regs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_irq_pending_threshold_cfg;
    timeunit 1ns;
    timeprecision 100ps;
    logic         ref_clk, rstn, sctl_system_reset_request_req, serviced, irq, sys_reset_req;
    logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic         s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]   s_axi_awaddr, s_axi_araddr;
    logic [31:0]  s_axi_wdata, s_axi_rdata, rv;
    logic [3:0]   s_axi_wstrb;
    logic [1:0]   s_axi_bresp, s_axi_rresp, rr, br;
    logic [39:0]  pend_cmd, src_pending, serviceable, exp_svc;
    logic [119:0] prio_cmd, src_prio;
    int           err_total = 0;
    int           checked = 0;
    int           pulse_cnt = 0;
    int           p0;

    ipt_core u_dut (.ref_clk(ref_clk), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .src_pending(src_pending), .src_prio(src_prio),
        .sctl_system_reset_request_req(sctl_system_reset_request_req), .serviceable(serviceable),
        .sys_reset_req(sys_reset_req), .irq(irq));
    ipt_src_model u_src (.ref_clk(ref_clk), .rstn(rstn), .pend_cmd(pend_cmd), .prio_cmd(prio_cmd),
        .serviceable(serviceable), .src_pending(src_pending), .src_prio(src_prio), .serviced(serviced));

    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (sys_reset_req === 1'b1) begin
            pulse_cnt <= pulse_cnt + 1;
        end
    end

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        if (err_total == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic hang(input int n);
        if (n > 60) begin
            $display("ERROR bus_wait exp answer got none");
            err_total++;
            stop_test();
        end
    endtask : hang

    // Address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, dn;
        int n;
        aw = 1'b1;
        w = 1'b1;
        dn = 1'b0;
        n = 0;
        @(posedge ref_clk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_bready <= 1'b1;
        while (!dn) begin
            @(posedge ref_clk);
            n++;
            if (!aw && !w && s_axi_bvalid === 1'b1) begin
                dn = 1'b1;
                br = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
            if (aw && s_axi_awready === 1'b1) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready === 1'b1) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
            hang(n);
        end
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic ar, dn;
        int n;
        ar = 1'b1;
        dn = 1'b0;
        n = 0;
        @(posedge ref_clk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        while (!dn) begin
            @(posedge ref_clk);
            n++;
            if (!ar && s_axi_rvalid === 1'b1) begin
                dn = 1'b1;
                rv = s_axi_rdata;
                rr = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
            if (ar && s_axi_arready === 1'b1) begin
                ar = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
            hang(n);
        end
    endtask : rd

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(`IPT_OFF_PEND3);
        `CHK("pend3_rst", 32'h0000_0000, rv)
        rd(`IPT_OFF_PEND4);
        `CHK("pend4_rst", 32'h0000_0000, rv)
        rd(`IPT_OFF_THRESH);
        `CHK("thr_rst", 32'h0000_0000, rv)
        rd(8'h10);
        `CHK("unmapped_resp", 2'h2, rr)
        `CHK("unmapped_data", 32'h0000_0000, rv)
        wr(8'h10, 32'hffff_ffff);
        `CHK("unmapped_wresp", 2'h2, br)
    endtask : t_reset

    // Writes to the read-only words must not disturb what they show
    task automatic t_pending();
        @(posedge ref_clk);
        pend_cmd <= 40'ha5_1234_5679;
        for (int i = 0; i < 40; i++) begin
            prio_cmd[3*i +: 3] <= 3'(i % 8);
        end
        repeat (3) @(posedge ref_clk);
        for (int k = 0; k < 2; k++) begin
            rd(`IPT_OFF_PEND3);
            `CHK("pend3", 32'h1234_5679, rv)
            rd(`IPT_OFF_PEND4);
            `CHK("pend4", 32'h0000_00a5, rv)
            wr(`IPT_OFF_PEND3, 32'hffff_ffff);
            wr(`IPT_OFF_PEND4, 32'hffff_ffff);
            `CHK("ro_wresp", 2'h0, br)
        end
    endtask : t_pending

    task automatic t_thresh();
        for (int i = 0; i < 40; i++) begin
            exp_svc[i] = (i % 8 >= 4) ? src_pending[i] : 1'b0;
        end
        wr(`IPT_OFF_THRESH, 32'hffff_ffff);
        rd(`IPT_OFF_THRESH);
        `CHK("thr_low_bits", 32'h0000_00e0, rv)
        wr(`IPT_OFF_THRESH, 32'h0000_009f);
        rd(`IPT_OFF_THRESH);
        `CHK("thr_four", 32'h0000_0080, rv)
        `CHK("svc_thr", exp_svc, serviceable)
        wr(`IPT_OFF_THRESH, 32'h0000_0000);
        repeat (2) @(posedge ref_clk);
        `CHK("svc_off", 40'ha5_1234_5679, serviceable)
        `CHK("serviced", 1'b1, serviced)
    endtask : t_thresh

    // Wrong key, zero request bit and reserved bits must not fire
    task automatic t_key();
        logic [31:0] bad [5] = '{32'hfa05_0080, 32'hbcaf_0080, 32'hbeef_0000, 32'h1234_0080, 32'hbeef_ff7f};
        wr(`IPT_OFF_IRQ_MASK, 32'h0000_0001);
        rd(`IPT_OFF_IRQ_STAT);
        `CHK("stat_events", 32'h0000_0006, rv)
        p0 = pulse_cnt;
        foreach (bad[k]) begin
            wr(`IPT_OFF_CFG, bad[k]);
            repeat (8) @(posedge ref_clk);
            `CHK("no_pulse", p0, pulse_cnt)
        end
        // Key bytes not strobed: the key is absent from this write
        s_axi_wstrb <= 4'h3;
        wr(`IPT_OFF_CFG, 32'hbeef_0080);
        s_axi_wstrb <= 4'hf;
        repeat (8) @(posedge ref_clk);
        `CHK("strb_no_pulse", p0, pulse_cnt)
        `CHK("irq_quiet", 1'b0, irq)
        wr(`IPT_OFF_CFG, 32'hbeef_0080);
        repeat (8) @(posedge ref_clk);
        `CHK("one_pulse", p0 + 1, pulse_cnt)
        `CHK("irq_set", 1'b1, irq)
        rd(`IPT_OFF_IRQ_STAT);
        `CHK("stat", 32'h0000_0001, rv)
        @(posedge ref_clk);
        `CHK("irq_clr", 1'b0, irq)
        rd(`IPT_OFF_CFG);
        `CHK("cfg_read", 32'h0000_0000, rv)
        @(posedge ref_clk);
        sctl_system_reset_request_req <= 1'b1;
        @(posedge ref_clk);
        sctl_system_reset_request_req <= 1'b0;
        repeat (8) @(posedge ref_clk);
        `CHK("sctl_pulse", p0 + 2, pulse_cnt)
    endtask : t_key

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        rstn = 1'b0;
        sctl_system_reset_request_req = 1'b0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hf;
        pend_cmd = 40'h00_0000_0000;
        prio_cmd = 120'h0;
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        t_pending();
        t_thresh();
        t_key();
        stop_test();
    end
endmodule : tb_irq_pending_threshold_cfg
